// >>> fra_defs.vh
// constants for the file register alu execution unit
`ifndef FRA_DEFS_VH
`define FRA_DEFS_VH

////////////////////////////////////////////////////////////////////////
// bus register byte addresses
`define FRA_A_INSN    8'h00
`define FRA_A_ACC     8'h04
`define FRA_A_FLAGS   8'h08
`define FRA_A_PC      8'h0C
`define FRA_A_TMRCFG  8'h10
`define FRA_A_PRESC   8'h14
`define FRA_A_PINS    8'h18
`define FRA_A_CYCLES  8'h1C
`define FRA_WIN_BIT   7

////////////////////////////////////////////////////////////////////////
// field positions
`define FRA_ST_C      0
`define FRA_ST_DC     1
`define FRA_ST_Z      2
`define FRA_INSN_BUSY 0
`define FRA_INSN_SKIP 1
`define FRA_CFG_PSA   0
`define FRA_CFG_RLO   1
`define FRA_CFG_RHI   3
`define FRA_PINS_DIRECTION_LATCH_LOAD 8

////////////////////////////////////////////////////////////////////////
// special file register addresses
`define FRA_F_TMR     5'h01
`define FRA_F_PCL     5'h02
`define FRA_F_STAT    5'h03
`define FRA_F_PORT    5'h06

////////////////////////////////////////////////////////////////////////
// opcode patterns
`define FRA_OP_ADDF   6'h07
`define FRA_OP_ANDF   6'h05
`define FRA_OP_MOVE_FILE_OP   6'h08
`define FRA_OP_BCF    4'h4
`define FRA_OP_BSF    4'h5
`define FRA_OP_BTC    4'h6
`define FRA_OP_BTS    4'h7
`define FRA_OP_ANDL   4'hE
`define FRA_OP_UNCONDITIONAL_BRANCH   3'h5
`define FRA_OP_TRIS6  12'h006

////////////////////////////////////////////////////////////////////////
// timing and reset values
`define FRA_OSC_PER_CYC 4
`define FRA_PH_COMMIT 3'h3
`define FRA_PH_LAST   3'h7
`define FRA_RST_DIRECTION_LATCH_LOAD  8'hFF
`define FRA_RST_BYTE  8'h00
`define FRA_RST_PC    9'h000
`define FRA_PC_STEP   9'h001
`define FRA_PC_SKIP   9'h002

`endif

// >>> fra_exec_unit.v
// execution unit for file register alu, bit and skip operations
`include "fra_defs.vh"

////////////////////////////////////////////////////////////////////////
// Contract
// - any pc write except the unconditional branch clears pc bit 8
// - read-modify-write of the port uses pin levels, not the latch
// - direction latch load with operand 6 copies acc to port direction
// - direction bit one floats the pin, zero drives it
// - marked op on timer with file destination clears assigned prescaler
// - add sums acc and file register, updates carry, nibble and zero
// - destination bit 0 writes acc, 1 writes the file register
// - and with file computes acc and file, updates only zero flag
// - and with literal ands acc with 8-bit literal into acc, sets zero
// - bit clear clears chosen bit, flags untouched
// - bit set sets chosen bit, flags untouched
// - test skip if clear skips when bit is zero, flags untouched
// - taken skip advances pc by two and idles a second cycle, two cycles
// - test skip if set skips when bit is one, same mechanism
// - one cycle of four clocks, two when skip or pc change
module fra_exec_unit (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // port pins
    input  wire [7:0]  pinIn,
    output reg  [7:0]  pinOut,
    output reg  [7:0]  pinOeN
);

    ////////////////////////////////////////////////////////////////////
    // state
    reg [7:0]  pinMeta;
    reg [7:0]  pinSync;
    reg [7:0]  acc;
    reg        flagC;
    reg        flagNibble;
    reg        flagZ;
    reg [8:0]  pc;
    reg        psaTimer;
    reg [2:0]  psRate;
    reg [7:0]  prescaler;
    reg [7:0]  timer;
    reg        busy;
    reg        skipped;
    reg [2:0]  phase;
    reg [11:0] insn;
    reg [15:0] cycleCount;
    reg [7:0]  fileMem [0:31];

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire       busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       busWr   = busReq & wb_we_i & ~busy;
    wire       laneLo  = wb_sel_i[0];
    wire       laneHi  = wb_sel_i[1];
    wire       inWin   = wb_adr_i[`FRA_WIN_BIT];
    wire [4:0] winAdr  = wb_adr_i[6:2];

    ////////////////////////////////////////////////////////////////////
    // operand fields
    wire [4:0] fAdr     = insn[4:0];
    wire       destFile = insn[5];
    wire [2:0] bitSel   = insn[7:5];
    wire [7:0] literal  = insn[7:0];
    wire [7:0] bitMask  = 8'h01 << bitSel;

    // opcode decode
    wire opAdd  = insn[11:6] == `FRA_OP_ADDF;
    wire opAndF = insn[11:6] == `FRA_OP_ANDF;
    wire opMov  = insn[11:6] == `FRA_OP_MOVE_FILE_OP;
    wire opBcf  = insn[11:8] == `FRA_OP_BCF;
    wire opBsf  = insn[11:8] == `FRA_OP_BSF;
    wire opBtc  = insn[11:8] == `FRA_OP_BTC;
    wire opBts  = insn[11:8] == `FRA_OP_BTS;
    wire opAndL = insn[11:8] == `FRA_OP_ANDL;
    wire opGoto = insn[11:9] == `FRA_OP_UNCONDITIONAL_BRANCH;
    wire opTris = insn == `FRA_OP_TRIS6;

    ////////////////////////////////////////////////////////////////////
    // file register read, used by the bus window only
    function [7:0] fileRead;
        input [4:0] adr;
        begin
            fileRead = fileMem[adr];
            if (adr == `FRA_F_TMR) begin
                fileRead = timer;
            end else if (adr == `FRA_F_PCL) begin
                fileRead = pc[7:0];
            end else if (adr == `FRA_F_STAT) begin
                fileRead = `FRA_RST_BYTE;
                fileRead[`FRA_ST_C]  = flagC;
                fileRead[`FRA_ST_DC] = flagNibble;
                fileRead[`FRA_ST_Z]  = flagZ;
            end else if (adr == `FRA_F_PORT) begin
                fileRead = pinSync;
            end
        end
    endfunction

    reg [7:0] fileRd;

    // operand read, written out so every source is in the sensitivity
    always @* begin
        fileRd = fileMem[fAdr];
        if (fAdr == `FRA_F_TMR) begin
            fileRd = timer;
        end else if (fAdr == `FRA_F_PCL) begin
            fileRd = pc[7:0];
        end else if (fAdr == `FRA_F_STAT) begin
            fileRd = `FRA_RST_BYTE;
            fileRd[`FRA_ST_C]  = flagC;
            fileRd[`FRA_ST_DC] = flagNibble;
            fileRd[`FRA_ST_Z]  = flagZ;
        end else if (fAdr == `FRA_F_PORT) begin
            fileRd = pinSync;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alu
    wire [8:0] sum    = {1'b0, acc} + {1'b0, fileRd};
    wire [4:0] nibSum = {1'b0, acc[3:0]} + {1'b0, fileRd[3:0]};

    reg [7:0] res;
    reg       toFile;
    reg       toAcc;
    reg       setZ;
    reg       setCarry;

    // result and destination select
    always @* begin
        res      = `FRA_RST_BYTE;
        toFile   = 1'b0;
        toAcc    = 1'b0;
        setZ     = 1'b0;
        setCarry = 1'b0;
        if (opAdd) begin
            res      = sum[7:0];
            toFile   = destFile;
            toAcc    = ~destFile;
            setZ     = 1'b1;
            setCarry = 1'b1;
        end else if (opAndF) begin
            res    = acc & fileRd;
            toFile = destFile;
            toAcc  = ~destFile;
            setZ   = 1'b1;
        end else if (opMov) begin
            res    = fileRd;
            toFile = destFile;
            toAcc  = ~destFile;
            setZ   = 1'b1;
        end else if (opAndL) begin
            res   = acc & literal;
            toAcc = 1'b1;
            setZ  = 1'b1;
        end else if (opBcf) begin
            res    = fileRd & ~bitMask;
            toFile = 1'b1;
        end else if (opBsf) begin
            res    = fileRd | bitMask;
            toFile = 1'b1;
        end
    end

    // skip, pc change and prescaler side effects
    wire bitVal    = |(fileRd & bitMask);
    wire skipTaken = (opBtc & ~bitVal) | (opBts & bitVal);
    wire pcWrite   = toFile & (fAdr == `FRA_F_PCL);
    wire twoCyc    = skipTaken | pcWrite | opGoto;
    wire tmrWrite  = toFile & (fAdr == `FRA_F_TMR);
    wire psClear   = psaTimer & tmrWrite;

    ////////////////////////////////////////////////////////////////////
    // instruction cycle timing: four clocks, commit on the fourth
    wire       commit   = busy & (phase == `FRA_PH_COMMIT);
    wire       lastPh   = busy & (phase == `FRA_PH_LAST);
    wire       cycTick  = commit | lastPh;
    wire [7:0] psMask   = (8'h02 << psRate) - 8'h01;
    wire       tmrTick  = ~psaTimer | ((prescaler & psMask) == psMask);

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta <= `FRA_RST_BYTE;
            pinSync <= `FRA_RST_BYTE;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // general file registers, no reset
    always @(posedge clk) begin
        if (commit & toFile) begin
            fileMem[fAdr] <= res;
        end else if (busWr & inWin & laneLo) begin
            fileMem[winAdr] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer, execution and register writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc        <= `FRA_RST_BYTE;
            flagC      <= 1'b0;
            flagNibble <= 1'b0;
            flagZ      <= 1'b0;
            pc         <= `FRA_RST_PC;
            psaTimer   <= 1'b0;
            psRate     <= 3'h0;
            prescaler  <= `FRA_RST_BYTE;
            timer      <= `FRA_RST_BYTE;
            busy       <= 1'b0;
            skipped    <= 1'b0;
            phase      <= 3'h0;
            insn       <= 12'h000;
            cycleCount <= 16'h0000;
            pinOut     <= `FRA_RST_BYTE;
            pinOeN     <= `FRA_RST_DIRECTION_LATCH_LOAD;
        end else begin
            // phase counter and end of instruction
            if (busy) begin
                phase <= phase + 3'h1;
                if ((commit & ~twoCyc) | lastPh) begin
                    busy <= 1'b0;
                end
            end
            if (cycTick) begin
                cycleCount <= cycleCount + 16'h0001;
            end
            // prescaler and timer advance per instruction cycle
            if (commit & psClear) begin
                prescaler <= `FRA_RST_BYTE;
            end else if (cycTick & psaTimer) begin
                prescaler <= prescaler + 8'h01;
            end
            if (commit & tmrWrite) begin
                timer <= res;
            end else if (cycTick & tmrTick) begin
                timer <= timer + 8'h01;
            end
            // commit of the executing instruction
            if (commit) begin
                skipped <= skipTaken;
                if (toAcc) begin
                    acc <= res;
                end
                if (toFile & (fAdr == `FRA_F_PORT)) begin
                    pinOut <= res;
                end
                if (opTris) begin
                    pinOeN <= acc;
                end
                if (toFile & (fAdr == `FRA_F_STAT)) begin
                    flagC      <= res[`FRA_ST_C];
                    flagNibble <= res[`FRA_ST_DC];
                    flagZ      <= res[`FRA_ST_Z];
                end
                if (setCarry) begin
                    flagC      <= sum[8];
                    flagNibble <= nibSum[4];
                end
                if (setZ) begin
                    flagZ <= (res == `FRA_RST_BYTE);
                end
                if (opGoto) begin
                    pc <= insn[8:0];
                end else if (pcWrite) begin
                    pc <= {1'b0, res};
                end else if (skipTaken) begin
                    pc <= pc + `FRA_PC_SKIP;
                end else begin
                    pc <= pc + `FRA_PC_STEP;
                end
            end
            // software writes, only while idle
            if (busWr & ~inWin) begin
                if (wb_adr_i == `FRA_A_INSN) begin
                    if (laneLo & laneHi) begin
                        insn  <= wb_dat_i[11:0];
                        busy  <= 1'b1;
                        phase <= 3'h0;
                    end
                end else if (wb_adr_i == `FRA_A_ACC) begin
                    if (laneLo) acc <= wb_dat_i[7:0];
                end else if (wb_adr_i == `FRA_A_FLAGS) begin
                    if (laneLo) begin
                        flagC      <= wb_dat_i[`FRA_ST_C];
                        flagNibble <= wb_dat_i[`FRA_ST_DC];
                        flagZ      <= wb_dat_i[`FRA_ST_Z];
                    end
                end else if (wb_adr_i == `FRA_A_PC) begin
                    if (laneLo) pc[7:0] <= wb_dat_i[7:0];
                    if (laneHi) pc[8] <= wb_dat_i[8];
                end else if (wb_adr_i == `FRA_A_TMRCFG) begin
                    if (laneLo) begin
                        psaTimer <= wb_dat_i[`FRA_CFG_PSA];
                        psRate   <= wb_dat_i[`FRA_CFG_RHI:`FRA_CFG_RLO];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus answer: ack one cycle after the request, read data with it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= 32'h00000000;
            if (busReq & ~wb_we_i) begin
                if (inWin) begin
                    wb_dat_o[7:0] <= fileRead(winAdr);
                end else if (wb_adr_i == `FRA_A_INSN) begin
                    wb_dat_o[`FRA_INSN_BUSY] <= busy;
                    wb_dat_o[`FRA_INSN_SKIP] <= skipped;
                end else if (wb_adr_i == `FRA_A_ACC) begin
                    wb_dat_o[7:0] <= acc;
                end else if (wb_adr_i == `FRA_A_FLAGS) begin
                    wb_dat_o[`FRA_ST_C]  <= flagC;
                    wb_dat_o[`FRA_ST_DC] <= flagNibble;
                    wb_dat_o[`FRA_ST_Z]  <= flagZ;
                end else if (wb_adr_i == `FRA_A_PC) begin
                    wb_dat_o[8:0] <= pc;
                end else if (wb_adr_i == `FRA_A_TMRCFG) begin
                    wb_dat_o[`FRA_CFG_PSA] <= psaTimer;
                    wb_dat_o[`FRA_CFG_RHI:`FRA_CFG_RLO] <= psRate;
                end else if (wb_adr_i == `FRA_A_PRESC) begin
                    wb_dat_o[7:0] <= prescaler;
                end else if (wb_adr_i == `FRA_A_PINS) begin
                    wb_dat_o[7:0]  <= pinSync;
                    wb_dat_o[15:8] <= pinOeN;
                end else if (wb_adr_i == `FRA_A_CYCLES) begin
                    wb_dat_o[15:0] <= cycleCount;
                end
            end
        end
    end

endmodule // fra_exec_unit

// >>> fra_pin_model.sv
// port pin model: external driver with pull-ups on every pin
module fra_pin_model (
    // chip side
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOeN,
    // external device
    input  wire logic [7:0] extEn,
    input  wire logic [7:0] extVal,
    output logic      [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // chip drives when enable low, else device, else pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pinOeN[i]) pinIn[i] = pinOut[i];
            else if (extEn[i]) pinIn[i] = extVal[i];
            else pinIn[i] = 1'b1;
        end
    end
endmodule // fra_pin_model

// >>> fra_exec_unit_properties.sv
// bus timing and pin cause checks for the execution unit
module fra_exec_unit_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic [7:0]  pinOut,
    input wire logic [7:0]  pinOeN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic       insnW;
    logic [3:0] since;
    assign insnW = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
        && wb_adr_i == 8'h00;
    // cycles since the last instruction write, saturating
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) since <= 4'hF;
        else if (insnW) since <= 4'h0;
        else if (since != 4'hF) since <= since + 4'h1;
    end
    sequence sReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sGapRd;
        sReq ##0 (!wb_we_i && wb_adr_i[7] == 1'b0 && wb_adr_i >= 8'h20);
    endsequence
    a_ack_follows_req: assert property (sReq |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_gap_reads_zero: assert property (sGapRd |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_dir_by_insn: assert property (
        $changed(pinOeN) |-> since <= 4'h9)
        else $error("direction changed without instruction");
    a_latch_by_insn: assert property (
        $changed(pinOut) |-> since <= 4'h9)
        else $error("pin latch changed without instruction");
    a_reset_pins_float: assert property (
        !$past(arst_n) |-> pinOeN == 8'hFF && pinOut == 8'h00)
        else $error("pins not floating after reset");
endmodule // fra_exec_unit_properties
bind fra_exec_unit fra_exec_unit_properties u_props (.clk(clk),
    .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pinOut(pinOut), .pinOeN(pinOeN));

// >>> fra_exec_unit_tb.sv
// self-checking bench for the execution unit
module fra_exec_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arstN, cyc, stb, wen, ack;
    logic [7:0] adr, pinIn, pinOut, pinOeN, extEn, extVal;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, c0;
    int fails, tests_run;
    fra_exec_unit u_dut (.clk(clk), .arst_n(arstN), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .pinIn(pinIn),
        .pinOut(pinOut), .pinOeN(pinOeN));
    fra_pin_model u_pins (.pinOut(pinOut), .pinOeN(pinOeN),
        .extEn(extEn), .extVal(extVal), .pinIn(pinIn));
    ////////////////////////////////////////////////////////////////////
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, wen, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        // no cycle count assumed: only the watchdog ends this wait
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(q, e);
    endtask
    // issue one instruction and poll busy
    task automatic ex(input logic [11:0] op);
        int n = 0;
        bus(8'h00, 1'b1, {20'h0, op});
        do begin bus(8'h00, 1'b0, 0); n++; end while (q[0] !== 1'b0 && n < 20);
        if (n >= 20) fails++;
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_add;
        bus(8'h04, 1, 32'h88); bus(8'h94, 1, 32'h88); ex(12'h1C5);
        rdc(8'h04, 32'h10);
        rdc(8'h08, 32'h3);
        bus(8'h04, 1, 32'h01); bus(8'h94, 1, 32'hFF); ex(12'h1E5);
        rdc(8'h94, 32'h00);
        rdc(8'h04, 32'h01);
        rdc(8'h08, 32'h7);
    endtask
    task t_and;
        bus(8'h08, 1, 32'h3); bus(8'h04, 1, 32'hF0); bus(8'h94, 1, 32'h0F);
        ex(12'h145);
        rdc(8'h04, 32'h00);
        rdc(8'h08, 32'h7);
        bus(8'h04, 1, 32'h5A); ex(12'hEFF);
        rdc(8'h04, 32'h5A);
        rdc(8'h08, 32'h3);
        ex(12'hE00);
        rdc(8'h08, 32'h7);
    endtask
    task t_bits;
        bus(8'h94, 1, 32'hF0); bus(8'h08, 1, 32'h5); ex(12'h4E5);
        rdc(8'h94, 32'h70);
        ex(12'h505);
        rdc(8'h94, 32'h71);
        rdc(8'h08, 32'h5);
    endtask
    // both tests against both bit values
    task t_skip;
        logic tk;
        for (int i = 0; i < 4; i++) begin
            tk = i[1] ? i[0] : !i[0];
            bus(8'h94, 1, {31'h0, i[0]}); bus(8'h0C, 1, 0); bus(8'h08, 1, 0);
            bus(8'h1C, 0, 0); c0 = q;
            ex(i[1] ? 12'h705 : 12'h605);
            chk(q[1], tk);
            rdc(8'h0C, tk ? 32'h2 : 32'h1);
            rdc(8'h1C, c0 + (tk ? 32'h2 : 32'h1));
            rdc(8'h08, 32'h0);
        end
    endtask
    task t_pc;
        bus(8'h0C, 1, 32'h1F0); bus(8'h04, 1, 1); bus(8'h1C, 0, 0); c0 = q;
        ex(12'h1E2); bus(8'h0C, 0, 0);
        chk(q[8], 1'b0);
        rdc(8'h1C, c0 + 32'h2);
        ex(12'hBFF);
        rdc(8'h0C, 32'h1FF);
    endtask
    task t_port;
        bus(8'h04, 1, 32'hFF); ex(12'h006);
        chk(pinOeN, 8'hFF);
        extEn <= 8'h02; extVal <= 8'h00;
        ex(12'h506);
        chk(pinOut, 8'hFD);
        bus(8'h04, 1, 32'h0F); ex(12'h006);
        rdc(8'h18, 32'h0FFD);
    endtask
    task t_timer;
        bus(8'h10, 1, 32'h1); ex(12'h521);
        rdc(8'h14, 32'h0);
        ex(12'h000); ex(12'h201);
        rdc(8'h14, 32'h2);
        ex(12'h221);
        rdc(8'h14, 32'h0);
    endtask
    task finish_test;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    // watchdog
    initial begin
        #200000;
        fails++;
        finish_test;
    end
    // main sequence
    initial begin
        {arstN, cyc, stb, wen, adr, wdat, sel, extEn, extVal} = 0;
        fails = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        arstN <= 1'b1;
        chk(pinOeN, 8'hFF);
        t_add; t_and; t_bits; t_skip; t_pc; t_port; t_timer;
        rdc(8'h40, 32'h0);
        finish_test;
    end
endmodule // fra_exec_unit_tb
